//--- pkg/ifo_pkg.sv
package ifo_pkg;

  // Register port geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Offset registers: four words, four streams each, at consecutive addresses.
  localparam int                OFS_REGS      = 4;
  localparam logic [ADDR_W-1:0] ADDR_OFS_BASE = 5'h03;
  localparam logic [DATA_W-1:0] OFS_RESET     = 16'h0000;

  // Measurement control, measurement result and receiver status words.
  localparam logic [ADDR_W-1:0] ADDR_MEAS_CTRL = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_MEAS_RES  = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_RX_STAT   = 5'h12;

  // Layout of one stream nibble.
  localparam int NIBBLE_W       = 4;
  localparam int FLD_LATCH_EDGE = 0;
  localparam int FLD_OFFSET_LSB = 1;
  localparam int OFFSET_W       = 3;
  localparam logic [OFFSET_W-1:0] OFFSET_MAX = 3'h4;

  // Measurement control and result fields.
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_OVERRUN_BIT = 1;
  localparam int RES_DONE_BIT     = 12;
  localparam int RES_FLAG_BIT     = 11;
  localparam int DELAY_W          = 11;

  // Receiver status fields.
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_PEND_BIT = 1;

  // Timing: the reference clock runs at twice the stream clock, so one
  // reference cycle is one half of a stream clock period.
  localparam int REF_PERIOD_NS    = 40;
  localparam int REF_PER_HALF_CLK = 1;
  localparam int BITS_PER_BYTE    = 8;
  localparam int CHAN_W           = 7;
  localparam int STREAM_W         = 4;

  // One received channel byte, tagged with its stream and channel.
  typedef struct packed {
    logic [STREAM_W-1:0] stream;
    logic [CHAN_W-1:0]   channel;
    logic [7:0]          data;
  } ifo_byte_s;

  // One register port request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ifo_req_s;

  // Frame delay measurement result.
  typedef struct packed {
    logic               done;
    logic               flag;
    logic [DELAY_W-1:0] delay;
  } ifo_meas_s;

endpackage

//--- rtl/ifo_fifo.sv
module ifo_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,       // Clock.
  input  wire logic             rst_i,       // Asynchronous reset, high.
  input  wire logic             in_valid_i,  // Write side offers a word.
  output logic                  in_ready_o,  // Room for one more word.
  input  wire logic [WIDTH-1:0] in_data_i,   // Word to store.
  output logic                  out_valid_o, // Head word is presented.
  input  wire logic             out_ready_i, // Reader takes the head word.
  output logic      [WIDTH-1:0] out_data_o   // Head word, from a register.
);

  localparam int AW = $clog2(DEPTH);

  // Refuse geometries the pointer arithmetic cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("ifo_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } ifo_fifo_s;

  ifo_fifo_s s_q;
  ifo_fifo_s s_d;
  logic      push;
  logic      load;

  // Full is honest: ready drops once DEPTH words wait in the array.
  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = s_q.ov;
  assign out_data_o  = s_q.od;
  assign push        = in_valid_i && in_ready_o;
  assign load        = (s_q.cnt != '0) && (!s_q.ov || out_ready_i);

  // Array write, head register refill and occupancy update.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp          = s_q.wp + AW'(1);
    end
    if (load) begin
      s_d.od = s_q.mem[s_q.rp];
      s_d.rp = s_q.rp + AW'(1);
      s_d.ov = 1'b1;
    end else if (out_ready_i) begin
      s_d.ov = 1'b0;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- rtl/ifo_frame_meas.sv
module ifo_frame_meas (
  input  wire logic              clk_i,         // Reference clock.
  input  wire logic              rst_i,         // Asynchronous reset, high.
  input  wire logic              frame_pulse_i, // Frame pulse, one cycle.
  input  wire logic              frame_eval_i,  // Frame evaluation input.
  input  wire logic              start_i,       // Measurement enable level.
  output ifo_pkg::ifo_meas_s     result_o       // Registered result.
);

  typedef struct packed {
    logic                        phase;
    logic                        fe_prev;
    logic                        counting;
    logic [ifo_pkg::DELAY_W+1:0] half_cnt;
    ifo_pkg::ifo_meas_s          res;
  } ifo_meas_state_s;

  ifo_meas_state_s s_q;
  ifo_meas_state_s s_d;

  assign result_o = s_q.res;

  // Phase is low in the stream clock high half, which starts at the pulse.
  // The falling edge of the evaluation input after a frame pulse is timed
  // in half periods; the phase it lands in gives the half-period flag.
  always_comb begin
    s_d         = s_q;
    s_d.phase   = frame_pulse_i ? 1'b1 : ~s_q.phase;
    s_d.fe_prev = frame_eval_i;
    if (!start_i) begin
      s_d.counting = 1'b0;
      s_d.half_cnt = '0;
      s_d.res      = '0;
    end else if (!s_q.res.done) begin
      if (frame_pulse_i && !s_q.counting) begin
        s_d.counting = 1'b1;
        s_d.half_cnt = (ifo_pkg::DELAY_W+2)'(1);
      end else if (s_q.counting) begin
        if (s_q.fe_prev && !frame_eval_i) begin
          s_d.counting  = 1'b0;
          s_d.res.done  = 1'b1;
          s_d.res.flag  = ~s_q.phase;                  // [RULE_10]
          s_d.res.delay = s_q.half_cnt[ifo_pkg::DELAY_W:1];
        end else if (s_q.half_cnt != '1) begin
          s_d.half_cnt = s_q.half_cnt + (ifo_pkg::DELAY_W+2)'(1);
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- rtl/ifo_input_offset.sv
// Contract
// RULE_01: Each stream's three-bit offset delays when its bit 0 is taken.
// RULE_02: Offset counts whole clock periods, up to four, from frame pulse.
// RULE_03: Latch-edge 1 samples at three quarters of the cell, 0 at half.
// RULE_04: Sixteen streams, 0 to 15, each with its own offset and edge bit.
// RULE_05: One nibble per stream, offset above edge bit, high stream on top.
// RULE_06: Offset 000 with edge bit 0 gives no shift and is the default.
// RULE_07: Shift is offset clocks plus half a clock when edge bit is 1.
// RULE_08: Largest shift is four and a half clocks, offset 100 edge 1.
// RULE_09: Software loads offset from delay low bits, edge as inverse flag.
// RULE_10: Measured phase flag is 1 in clock high half, 0 in low half.
// RULE_11: Offset registers are read/write and reset to zero.
// RULE_12: After the offset, one bit per cell until the next frame pulse; the code samples only CHANNELS bytes (FRAME_CYC cycles) per pulse.
module ifo_input_offset #(
  parameter int STREAMS     = 16,
  parameter int CLK_PER_BIT = 2,
  parameter int CHANNELS    = 128,
  parameter int FIFO_DEPTH  = 16
) (
  input  wire logic                        REF_CLK_I,          // Clock.
  input  wire logic                        RST_I,              // Reset.
  input  wire logic [ifo_pkg::ADDR_W-1:0]  REG_ADDR_I,         // Address.
  input  wire logic [ifo_pkg::DATA_W-1:0]  REG_WDATA_I,        // Wr data.
  input  wire logic                        REG_WR_I,           // Wr strobe.
  input  wire logic                        REG_RD_I,           // Rd strobe.
  output logic      [ifo_pkg::DATA_W-1:0]  REG_RDATA_O,        // Rd data.
  input  wire logic                        FRAME_PULSE_IN_I,   // Frame.
  input  wire logic                        FRAME_EVAL_IN_I,    // Eval pin.
  input  wire logic [STREAMS-1:0]          SERIAL_STREAM_IN_I, // Data.
  output logic                             RX_VALID_O,         // Byte out.
  input  wire logic                        RX_READY_I,         // Taken.
  output ifo_pkg::ifo_byte_s               RX_DATA_O           // Byte.
);

  // One reference cycle is half a stream clock; a cell is a power of two.
  localparam int CELL      = CLK_PER_BIT * 2 * ifo_pkg::REF_PER_HALF_CLK;
  localparam int CELL_W    = $clog2(CELL);
  localparam int CNT_W     = CELL_W + 3 + ifo_pkg::CHAN_W + 1;
  localparam int BYTE_W    = ifo_pkg::CHAN_W + 8;
  localparam int FRAME_INT = CHANNELS * ifo_pkg::BITS_PER_BYTE * CELL;
  localparam logic [CNT_W-1:0] FRAME_CYC  = CNT_W'(FRAME_INT);
  localparam logic [CNT_W-1:0] SAMPLE_PT  = CNT_W'(CELL / 2);
  localparam logic [CNT_W-1:0] CNT_LIMIT  = CNT_W'(FRAME_INT + 2 * CELL);
  localparam logic [2:0]       LAST_BIT   = 3'h7;

  // Refuse settings the register map or the bit counters cannot serve.
  if (STREAMS < 1 || STREAMS > 16 || CELL < 2 || (1 << CELL_W) != CELL ||
      CHANNELS < 1 || CHANNELS > (1 << ifo_pkg::CHAN_W)) begin : g_chk
    $error("ifo_input_offset: unsupported stream, rate or channel count");
  end

  typedef struct packed {
    logic [ifo_pkg::OFS_REGS-1:0][ifo_pkg::DATA_W-1:0] ofs;
    logic [ifo_pkg::DATA_W-1:0]                        rd_data;
    logic                                              start;
    logic                                              overrun;
    logic                                              run;
    logic [CNT_W-1:0]                                  cnt;
    logic [STREAMS-1:0][6:0]                           sr;
    logic [STREAMS-1:0]                                pend;
    logic [STREAMS-1:0][BYTE_W-1:0]                    pbyte;
  } ifo_core_s;

  ifo_core_s                 s_q;
  ifo_core_s                 s_d;
  ifo_pkg::ifo_req_s         req;
  ifo_pkg::ifo_meas_s        meas;
  ifo_pkg::ifo_byte_s        push_byte;
  logic [STREAMS-1:0]        samp;
  logic [STREAMS-1:0][2:0]   bit_idx;
  logic [STREAMS-1:0][6:0]   chan;
  logic                      pick_valid;
  logic [3:0]                pick;
  logic                      fifo_ready;
  logic                      pop;

  assign req         = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I,
                         wdata: REG_WDATA_I};
  assign REG_RDATA_O = s_q.rd_data;

  // Per-stream alignment: shift in half periods, then cell position.
  for (genvar g = 0; g < STREAMS; g++) begin : g_stream
    logic [ifo_pkg::NIBBLE_W-1:0] nib;
    logic [ifo_pkg::OFFSET_W-1:0] ofs_raw;
    logic [ifo_pkg::OFFSET_W-1:0] ofs_sat;
    logic                         dle;
    logic [CNT_W-1:0]             shift;
    logic [CNT_W-1:0]             pos;
    logic                         active;

    // Stream g sits in nibble g mod 4 of word g div 4.
    assign nib     = s_q.ofs[g / 4][(g % 4) * ifo_pkg::NIBBLE_W +:
                                    ifo_pkg::NIBBLE_W];     // [RULE_05] [RULE_04]
    assign ofs_raw = nib[ifo_pkg::FLD_OFFSET_LSB +: ifo_pkg::OFFSET_W];
    assign dle     = nib[ifo_pkg::FLD_LATCH_EDGE];
    // Offsets past four clocks are held at four.
    assign ofs_sat = (ofs_raw > ifo_pkg::OFFSET_MAX) ?
                     ifo_pkg::OFFSET_MAX : ofs_raw;          // [RULE_02] [RULE_08]
    // Whole clocks count two half periods, the edge bit adds one.
    assign shift   = CNT_W'({ofs_sat, dle}) *
                     CNT_W'(ifo_pkg::REF_PER_HALF_CLK);     // [RULE_07] [RULE_06]
    assign pos     = s_q.cnt - shift;                       // [RULE_01]
    assign active  = s_q.run && (s_q.cnt >= shift) && (pos < FRAME_CYC);
    // The half-cell point of the shifted cell is the three-quarter point
    // of the unshifted cell when the edge bit adds its half period.
    assign samp[g]    = active &&
                        (pos[CELL_W-1:0] == SAMPLE_PT[CELL_W-1:0]); // [RULE_03]
    assign bit_idx[g] = pos[CELL_W +: 3];
    assign chan[g]    = pos[CELL_W + 3 +: ifo_pkg::CHAN_W];
  end

  // Lowest-numbered stream with a finished byte goes to the FIFO next.
  // All streams finish within a few cycles of each other, and a byte
  // lasts 8 cells, so a fixed priority drains every stream in time.
  always_comb begin
    pick_valid = 1'b0;
    pick       = '0;
    for (int i = STREAMS - 1; i >= 0; i--) begin
      if (s_q.pend[i]) begin
        pick_valid = 1'b1;
        pick       = 4'(i);
      end
    end
  end

  assign pop       = pick_valid && fifo_ready;
  assign push_byte = '{stream: pick,
                       channel: s_q.pbyte[pick][8 +: ifo_pkg::CHAN_W],
                       data: s_q.pbyte[pick][7:0]};

  // Register port, frame counter and per-stream deserialisers.
  always_comb begin
    s_d         = s_q;
    s_d.rd_data = '0;

    // Writes to the offset words and the measurement control word.
    if (req.wr) begin
      for (int r = 0; r < ifo_pkg::OFS_REGS; r++) begin
        if (req.addr == ifo_pkg::ADDR_OFS_BASE + ifo_pkg::ADDR_W'(r)) begin
          s_d.ofs[r] = req.wdata;                         // [RULE_11]
        end
      end
      if (req.addr == ifo_pkg::ADDR_MEAS_CTRL) begin
        s_d.start = req.wdata[ifo_pkg::CTRL_START_BIT];
        if (req.wdata[ifo_pkg::CTRL_OVERRUN_BIT]) begin
          s_d.overrun = 1'b0;
        end
      end
    end

    // Reads answer in the following cycle; unmapped words read zero.
    if (req.rd) begin
      for (int r = 0; r < ifo_pkg::OFS_REGS; r++) begin
        if (req.addr == ifo_pkg::ADDR_OFS_BASE + ifo_pkg::ADDR_W'(r)) begin
          s_d.rd_data = s_q.ofs[r];                       // [RULE_11]
        end
      end
      if (req.addr == ifo_pkg::ADDR_MEAS_CTRL) begin
        s_d.rd_data[ifo_pkg::CTRL_START_BIT]   = s_q.start;
        s_d.rd_data[ifo_pkg::CTRL_OVERRUN_BIT] = s_q.overrun;
      end
      if (req.addr == ifo_pkg::ADDR_MEAS_RES) begin
        s_d.rd_data[ifo_pkg::RES_DONE_BIT]      = meas.done;
        s_d.rd_data[ifo_pkg::RES_FLAG_BIT]      = meas.flag;
        s_d.rd_data[ifo_pkg::DELAY_W-1:0]       = meas.delay;
      end
      if (req.addr == ifo_pkg::ADDR_RX_STAT) begin
        s_d.rd_data[ifo_pkg::STAT_RUN_BIT]  = s_q.run;
        s_d.rd_data[ifo_pkg::STAT_PEND_BIT] = |s_q.pend;
      end
    end

    // Time since the last frame pulse; a new pulse restarts alignment.
    if (FRAME_PULSE_IN_I) begin
      s_d.run = 1'b1;
      s_d.cnt = CNT_W'(1);                               // [RULE_12] [RULE_02]
    end else if (s_q.run && s_q.cnt != CNT_LIMIT) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end

    // A byte handed to the FIFO frees its holding slot.
    if (pop) begin
      s_d.pend[pick] = 1'b0;
    end

    // One bit per cell; the eighth bit completes a channel byte.
    for (int i = 0; i < STREAMS; i++) begin
      if (samp[i]) begin                                 // [RULE_12]
        if (bit_idx[i] == LAST_BIT) begin
          if (s_q.pend[i] && !(pop && pick == 4'(i))) begin
            s_d.overrun = 1'b1;
          end
          s_d.pend[i]  = 1'b1;
          s_d.pbyte[i] = {chan[i], s_q.sr[i], SERIAL_STREAM_IN_I[i]};
        end else begin
          s_d.sr[i] = {s_q.sr[i][5:0], SERIAL_STREAM_IN_I[i]};
        end
      end
    end
  end

  // State register; offset words come up at their zero reset value.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q     <= '0;
      s_q.ofs <= {ifo_pkg::OFS_REGS{ifo_pkg::OFS_RESET}};  // [RULE_11] [RULE_06]
    end else begin
      s_q <= s_d;
    end
  end

  // Frame delay measurement feeding the result word.
  ifo_frame_meas u_meas (
    .clk_i         (REF_CLK_I),
    .rst_i         (RST_I),
    .frame_pulse_i (FRAME_PULSE_IN_I),
    .frame_eval_i  (FRAME_EVAL_IN_I),
    .start_i       (s_q.start),
    .result_o      (meas)
  );

  // Received channel bytes wait here for the consumer.
  ifo_fifo #(
    .WIDTH ($bits(ifo_pkg::ifo_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (pick_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_byte),
    .out_valid_o (RX_VALID_O),
    .out_ready_i (RX_READY_I),
    .out_data_o  (RX_DATA_O)
  );

endmodule

//--- tb/ifo_input_offset_sva.sv
module ifo_input_offset_sva #(
  parameter int CHANNELS = 128
) (
  input wire logic                       REF_CLK_I,        // Clock.
  input wire logic                       RST_I,            // Reset.
  input wire logic [ifo_pkg::ADDR_W-1:0] REG_ADDR_I,       // Address.
  input wire logic [ifo_pkg::DATA_W-1:0] REG_WDATA_I,      // Wr data.
  input wire logic                       REG_WR_I,         // Wr strobe.
  input wire logic                       REG_RD_I,         // Rd strobe.
  input wire logic [ifo_pkg::DATA_W-1:0] REG_RDATA_O,      // Rd data.
  input wire logic                       FRAME_PULSE_IN_I, // Frame.
  input wire logic                       RX_VALID_O,       // Byte out.
  input wire logic                       RX_READY_I,       // Taken.
  input wire ifo_pkg::ifo_byte_s         RX_DATA_O         // Byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ifo_pkg::DATA_W-1:0] ofs_q [4];
  logic                       seen_q;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  // Address decode of the offset words and of every mapped word.
  function automatic logic is_ofs(input logic [ifo_pkg::ADDR_W-1:0] a);
    return a >= ifo_pkg::ADDR_OFS_BASE && a < ifo_pkg::ADDR_OFS_BASE + 5'h04;
  endfunction
  function automatic logic is_map(input logic [ifo_pkg::ADDR_W-1:0] a);
    return is_ofs(a) || (a >= 5'h10 && a <= 5'h12);
  endfunction

  // Shadow of the offset words and a flag for the first frame pulse.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ofs_q  <= '{default: ifo_pkg::OFS_RESET};
      seen_q <= 1'b0;
    end else begin
      if (REG_WR_I && is_ofs(REG_ADDR_I)) begin
        ofs_q[2'(REG_ADDR_I - ifo_pkg::ADDR_OFS_BASE)] <= REG_WDATA_I;
      end
      if (FRAME_PULSE_IN_I) begin
        seen_q <= 1'b1;
      end
    end
  end

  property p_rdata_idle;
    !$past(REG_RD_I) |-> REG_RDATA_O == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
  property p_ofs_read;
    $past(REG_RD_I) && is_ofs($past(REG_ADDR_I)) |-> REG_RDATA_O ==
      ofs_q[2'($past(REG_ADDR_I) - ifo_pkg::ADDR_OFS_BASE)];
  endproperty
  a_ofs_read: assert property (p_ofs_read)
    else $error("offset word readback wrong");
  property p_unmapped;
    $past(REG_RD_I) && !is_map($past(REG_ADDR_I)) |-> REG_RDATA_O == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_no_early;
    !seen_q |-> !RX_VALID_O;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("byte before any frame");
  property p_first_lat;
    FRAME_PULSE_IN_I && !seen_q |=> (!RX_VALID_O) [*8] ##1
      (!RX_VALID_O) [*8] ##1 (!RX_VALID_O) [*8] ##1 (!RX_VALID_O) [*8];
  endproperty
  a_first_lat: assert property (p_first_lat)
    else $error("first byte too early");
  property p_chan;
    RX_VALID_O |-> RX_DATA_O.channel < CHANNELS;
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel out of range");
  property p_hold;
    RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte dropped while stalled");
  property p_reset_out;
    $fell(RST_I) |-> !RX_VALID_O && REG_RDATA_O == '0;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared by reset");

  c_wr: cover property (REG_WR_I && is_ofs(REG_ADDR_I));
  c_take: cover property (RX_VALID_O && RX_READY_I);
  c_stall: cover property (RX_VALID_O && !RX_READY_I ##1 RX_VALID_O);
endmodule

bind ifo_input_offset ifo_input_offset_sva #(.CHANNELS(CHANNELS)) u_sva (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .FRAME_PULSE_IN_I(FRAME_PULSE_IN_I),
  .RX_VALID_O(RX_VALID_O), .RX_READY_I(RX_READY_I), .RX_DATA_O(RX_DATA_O)
);

//--- tb/ifo_stream_src.sv
module ifo_stream_src #(
  parameter int STREAMS  = 16,
  parameter int CHANNELS = 2
) (
  input  wire logic                    clk_i,         // Clock.
  input  wire logic                    rst_i,         // Reset, high.
  input  wire logic                    frame_pulse_i, // Frame start.
  input  wire logic [STREAMS-1:0][3:0] shift_i,       // Shift, half clocks.
  output logic      [STREAMS-1:0]      stream_o       // Serial lines.
);
  timeunit 1ns;
  timeprecision 1ps;
  int   t_q;
  logic run_q;
  logic tog_q;

  // Byte that stream s carries in channel c.
  function automatic logic [7:0] pat(input int s, input int c);
    return 8'(8'h5A ^ (s * 8'h13) ^ (c * 8'h6C));
  endfunction

  // Counts reference cycles from the pulse; the toggle feeds idle noise.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_q   <= 0;
      run_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (frame_pulse_i) begin
        t_q   <= 1;
        run_q <= 1'b1;
      end else if (run_q) begin
        t_q   <= t_q + 1;
        run_q <= t_q < 40 * CHANNELS;
      end
    end
  end

  // Each bit holds for one four-cycle cell after the stream's shift.
  always_comb begin
    int         rel;
    logic [7:0] b;
    rel = 0;
    b   = '0;
    for (int s = 0; s < STREAMS; s++) begin
      rel = t_q - int'(shift_i[s]);
      b = pat(s, rel / 32);
      stream_o[s] = tog_q ^ s[0];
      if (run_q && rel >= 0 && rel < 32 * CHANNELS) begin
        stream_o[s] = b[7 - (rel / 4) % 8];
      end
    end
  end
endmodule

//--- tb/ifo_input_offset_tb.sv
module ifo_input_offset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0]  a;
    logic [15:0] w;
    logic [15:0] e;
  } ifo_row_s;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [4:0]         addr = '0;
  logic [15:0]        wdata = '0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               fp = 1'b0;
  logic               fe = 1'b1;
  logic               rdy = 1'b0;
  logic [15:0][3:0]   shift = '0;
  logic [15:0]        rdata;
  logic [15:0]        ser;
  logic               rx_valid;
  ifo_pkg::ifo_byte_s rx_data;
  logic [15:0]        v;
  logic [31:0]        mask;
  int                 errors = 0;
  int                 cmp_count = 0;
  int                 n;
  ifo_row_s rows [6] = '{'{5'h03, 16'hA5C3, 16'hA5C3},
    '{5'h04, 16'h5A3C, 16'h5A3C}, '{5'h06, 16'hFFFF, 16'hFFFF},
    '{5'h07, 16'h1234, 16'h0000}, '{5'h11, 16'hFFFF, 16'h0000},
    '{5'h1F, 16'hBEEF, 16'h0000}};

  ifo_input_offset #(.CHANNELS(2)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .FRAME_PULSE_IN_I(fp), .FRAME_EVAL_IN_I(fe), .SERIAL_STREAM_IN_I(ser),
    .RX_VALID_O(rx_valid), .RX_READY_I(rdy), .RX_DATA_O(rx_data)
  );
  ifo_stream_src #(.STREAMS(16), .CHANNELS(2)) u_src (
    .clk_i(clk), .rst_i(rst), .frame_pulse_i(fp), .shift_i(shift),
    .stream_o(ser)
  );

  // Free-running reference clock.
  always #20 clk = ~clk;

  // Comparison, register access and verdict helpers.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Byte that stream s carries in channel c, as the sources send it.
  function automatic logic [7:0] pat(input int s, input int c);
    return 8'(8'h5A ^ (s * 8'h13) ^ (c * 8'h6C));
  endfunction
  function automatic logic [3:0] nib(input logic [2:0] d, input logic f);
    return {d, ~f};
  endfunction
  task automatic pulse();
    @(posedge clk);
    fp <= 1'b1;
    @(posedge clk);
    fp <= 1'b0;
  endtask
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence: reset, register table, offset sweep, measurement.
  initial begin
    logic [3:0][15:0] wd;
    int o;
    int e;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 check(rx_valid, 1'b0);
    for (int i = 0; i < 4; i++) begin
      reg_rd(ifo_pkg::ADDR_OFS_BASE + 5'(i), v);
      check(v, ifo_pkg::OFS_RESET);
    end
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].w);
      reg_rd(rows[i].a, v);
      check(v, rows[i].e);
    end
    wd = '0;
    for (int s = 0; s < 16; s++) begin
      o = s % 8;
      e = s / 8;
      wd[s/4][4*(s%4)+:4] = nib(3'(o), !e[0]);
      shift[s] <= 4'(2 * (o > 4 ? 4 : o) + e);
    end
    for (int i = 0; i < 4; i++) begin
      reg_wr(ifo_pkg::ADDR_OFS_BASE + 5'(i), wd[i]);
    end
    pulse();
    repeat (120) @(posedge clk);
    reg_rd(ifo_pkg::ADDR_RX_STAT, v);
    check(v, 16'h0003);
    @(posedge clk);
    rdy <= 1'b1;
    mask = '0;
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if (rx_valid === 1'b1) begin
        n++;
        mask[{rx_data.stream, rx_data.channel[0]}] = 1'b1;
        check(rx_data.data, pat(rx_data.stream,
          rx_data.channel));
      end
    end
    check(n, 32);
    check(mask, 32'hFFFFFFFF);
    reg_rd(ifo_pkg::ADDR_MEAS_CTRL, v);
    check(v, 16'h0000);
    // A stalled consumer and a second frame overwrite waiting bytes.
    rdy <= 1'b0;
    repeat (2) begin
      pulse();
      repeat (80) @(posedge clk);
    end
    reg_rd(ifo_pkg::ADDR_MEAS_CTRL, v);
    check(v, 16'h0002);
    reg_wr(ifo_pkg::ADDR_MEAS_CTRL, 16'h0002);
    reg_rd(ifo_pkg::ADDR_MEAS_CTRL, v);
    check(v, 16'h0000);
    rdy <= 1'b1;
    repeat (60) @(posedge clk);
    for (int k = 5; k <= 9; k++) begin
      reg_wr(ifo_pkg::ADDR_MEAS_CTRL, 16'h0001);
      pulse();
      repeat (k - 1) @(posedge clk);
      fe <= 1'b0;
      repeat (4) @(posedge clk);
      reg_rd(ifo_pkg::ADDR_MEAS_RES, v);
      check(v, 16'h1000 | (k % 2 == 0 ? 16'h0800 : 16'h0000)
        | 16'(k / 2));
      @(posedge clk);
      fe <= 1'b1;
      reg_wr(ifo_pkg::ADDR_MEAS_CTRL, 16'h0000);
      reg_rd(ifo_pkg::ADDR_MEAS_RES, v);
      check(v, 16'h0000);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(ifo_pkg::ADDR_OFS_BASE, v);
    check(v, ifo_pkg::OFS_RESET);
    check(rx_valid, 1'b0);
    complete_run();
  end
endmodule
